// file: core/ulf_line_format.sv
// Line format register and frame control for one asynchronous serial port.
`timescale 1ns/1ps

module ulf_line_format (
  // Clock and reset
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_b,
  // Register port
  input  wire logic [ulf_pkg::ADDR_W-1:0]    i_reg_addr,
  input  wire logic [ulf_pkg::DATA_W-1:0]    i_reg_wdata,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  output logic      [ulf_pkg::DATA_W-1:0]    o_reg_rdata,
  // Transmit side
  input  wire logic                          i_tx_shift_bit,
  input  wire logic [7:0]                    i_tx_char,
  output logic                               o_serial_tx_line,
  output logic                               o_tx_parity_bit,
  // Receive side
  input  wire logic [7:0]                    i_rx_char,
  input  wire logic                          i_rx_parity_bit,
  input  wire logic                          i_rx_char_valid,
  output logic                               o_rx_parity_err,
  // Frame setup and queue control
  output ulf_pkg::ulf_frame_type             o_frame,
  output logic                               o_rx_queue_enable,
  output logic                               o_rx_flow_ctrl_on,
  output logic                               o_rx_queue_reinit
);

  // Decoded frame and parity signals between the register and the flops.
  ulf_pkg::ulf_line_format_type serial_line_format_r;
  ulf_pkg::ulf_frame_type       frame_nxt;
  logic [7:0]                   char_mask;
  logic                         tx_parity_nxt;
  logic                         rx_parity_exp;
  logic                         rx_parity_err_r;
  logic                         rx_queue_enable_d_r;

  // Register write; all fields reset to zero and read back as written.
  // Writes to any other offset are dropped, so the status word stays
  // read-only.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      serial_line_format_r <= ulf_pkg::LINE_FORMAT_RST;
    end else if (i_reg_wr && i_reg_addr == ulf_pkg::OFS_LINE_FORMAT) begin
      serial_line_format_r <= i_reg_wdata;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  // Unmapped offsets read as zero rather than aliasing the format word.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        ulf_pkg::OFS_LINE_FORMAT: begin
          o_reg_rdata <= serial_line_format_r;
        end
        ulf_pkg::OFS_LINE_STATUS: begin
          o_reg_rdata <= {6'h00, rx_parity_err_r, o_serial_tx_line};
        end
        default: begin
          o_reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // Frame decode and the mask that drops unused high data bits.
  // The frame word is registered, so the shifters see a settled setup one
  // cycle after the register write, never a half-written one.
  always_comb begin
    frame_nxt.parity_on = serial_line_format_r.parity_on;
    case (serial_line_format_r.char_size_code)
      ulf_pkg::CHAR_SIZE_5: begin
        frame_nxt.char_bits = ulf_pkg::CHAR_BITS_5;
        char_mask           = 8'h1f;
      end
      ulf_pkg::CHAR_SIZE_6: begin
        frame_nxt.char_bits = ulf_pkg::CHAR_BITS_6;
        char_mask           = 8'h3f;
      end
      ulf_pkg::CHAR_SIZE_7: begin
        frame_nxt.char_bits = ulf_pkg::CHAR_BITS_7;
        char_mask           = 8'h7f;
      end
      default: begin
        frame_nxt.char_bits = ulf_pkg::CHAR_BITS_8;
        char_mask           = 8'hff;
      end
    endcase
    if (!serial_line_format_r.stop_bit_select) begin
      frame_nxt.stop_half_bits = ulf_pkg::STOP_HALF_1;
    end else if (serial_line_format_r.char_size_code ==
                 ulf_pkg::CHAR_SIZE_5) begin
      frame_nxt.stop_half_bits = ulf_pkg::STOP_HALF_1P5;
    end else begin
      frame_nxt.stop_half_bits = ulf_pkg::STOP_HALF_2;
    end
  end

  // The same parity rule serves the sending and the checking side.
  ulf_parity_calc #(
    .WIDTH (ulf_pkg::DATA_W)
  ) tx_parity_i (
    .i_data              (i_tx_char),
    .i_mask              (char_mask),
    .i_parity_force      (serial_line_format_r.parity_force),
    .i_parity_sense_even (serial_line_format_r.parity_sense_even),
    .o_parity            (tx_parity_nxt)
  );

  ulf_parity_calc #(
    .WIDTH (ulf_pkg::DATA_W)
  ) rx_parity_i (
    .i_data              (i_rx_char),
    .i_mask              (char_mask),
    .i_parity_force      (serial_line_format_r.parity_force),
    .i_parity_sense_even (serial_line_format_r.parity_sense_even),
    .o_parity            (rx_parity_exp)
  );

  // Frame setup and transmit parity are registered so that every output
  // comes straight from a flip-flop.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_frame         <= '0;
      o_tx_parity_bit <= 1'b0;
    end else begin
      o_frame         <= frame_nxt;
      o_tx_parity_bit <= tx_parity_nxt;
    end
  end

  // Break overrides whatever the shifter is sending.
  // It is applied ahead of the output flop, so the line never glitches high
  // between two characters while the field stays set.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_serial_tx_line <= ulf_pkg::SERIAL_IDLE;
    end else if (serial_line_format_r.line_break_force) begin
      o_serial_tx_line <= ulf_pkg::SERIAL_BREAK;
    end else begin
      o_serial_tx_line <= i_tx_shift_bit;
    end
  end

  // Parity error flag: checked only with parity on, sticky until the next
  // received character so software can sample it through the status word.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      rx_parity_err_r <= 1'b0;
    end else if (i_rx_char_valid) begin
      rx_parity_err_r <= serial_line_format_r.parity_on &&
                         (i_rx_parity_bit != rx_parity_exp);
    end
  end

  assign o_rx_parity_err = rx_parity_err_r;

  // Queue enable and flow control follow the field; a rising edge of the
  // field gives a one-cycle reinitialise pulse to the receive queue.
  // The pulse rides on the registered field, so a write that leaves the
  // field set gives no second pulse.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      rx_queue_enable_d_r <= 1'b0;
      o_rx_queue_enable   <= 1'b0;
      o_rx_flow_ctrl_on   <= 1'b0;
      o_rx_queue_reinit   <= 1'b0;
    end else begin
      rx_queue_enable_d_r <= serial_line_format_r.rx_queue_enable;
      o_rx_queue_enable   <= serial_line_format_r.rx_queue_enable;
      o_rx_flow_ctrl_on   <= serial_line_format_r.rx_queue_enable;
      o_rx_queue_reinit   <= serial_line_format_r.rx_queue_enable &&
                             !rx_queue_enable_d_r;
    end
  end

endmodule

// Parity over the live data bits of one character; forcing ignores data.
// Odd sense wants the ones of data and parity bit together to be odd.
module ulf_parity_calc #(
  parameter int unsigned WIDTH = 8
) (
  // Character and the mask of its live bits
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic [WIDTH-1:0] i_mask,
  // Parity options from the line format
  input  wire logic             i_parity_force,
  input  wire logic             i_parity_sense_even,
  // Parity bit to send or to expect
  output logic                  o_parity
);

  logic data_ones_odd;

  // For odd sense the bit is the inverted reduction, for even sense the
  // plain one; a forced bit is the inverse of the sense field.
  always_comb begin
    data_ones_odd = ^(i_data & i_mask);
    if (i_parity_force) begin
      o_parity = ~i_parity_sense_even;
    end else begin
      o_parity = data_ones_odd ^ ~i_parity_sense_even;
    end
  end

endmodule

// file: core/ulf_pkg.sv
// Register map, field layout and frame types of the line format block.
package ulf_pkg;

  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;

  localparam logic [1:0] OFS_LINE_FORMAT = 2'h0;
  localparam logic [1:0] OFS_LINE_STATUS = 2'h1;

  localparam logic [7:0] LINE_FORMAT_RST = 8'h00;

  localparam int unsigned POS_CHAR_SIZE_LO      = 0;
  localparam int unsigned POS_STOP_BIT_SELECT   = 2;
  localparam int unsigned POS_PARITY_ON         = 3;
  localparam int unsigned POS_PARITY_SENSE_EVEN = 4;
  localparam int unsigned POS_PARITY_FORCE      = 5;
  localparam int unsigned POS_LINE_BREAK_FORCE  = 6;
  localparam int unsigned POS_RX_QUEUE_ENABLE   = 7;

  localparam logic [1:0] CHAR_SIZE_5 = 2'h0;
  localparam logic [1:0] CHAR_SIZE_6 = 2'h1;
  localparam logic [1:0] CHAR_SIZE_7 = 2'h2;
  localparam logic [1:0] CHAR_SIZE_8 = 2'h3;

  localparam logic [3:0] CHAR_BITS_5 = 4'h5;
  localparam logic [3:0] CHAR_BITS_6 = 4'h6;
  localparam logic [3:0] CHAR_BITS_7 = 4'h7;
  localparam logic [3:0] CHAR_BITS_8 = 4'h8;

  // Stop length in half bit times: 1, 1.5 and 2 stop bits.
  localparam logic [2:0] STOP_HALF_1   = 3'h2;
  localparam logic [2:0] STOP_HALF_1P5 = 3'h3;
  localparam logic [2:0] STOP_HALF_2   = 3'h4;

  localparam logic SERIAL_IDLE  = 1'b1;
  localparam logic SERIAL_BREAK = 1'b0;

  typedef struct packed {
    logic       rx_queue_enable;
    logic       line_break_force;
    logic       parity_force;
    logic       parity_sense_even;
    logic       parity_on;
    logic       stop_bit_select;
    logic [1:0] char_size_code;
  } ulf_line_format_type;

  typedef struct packed {
    logic [3:0] char_bits;
    logic [2:0] stop_half_bits;
    logic       parity_on;
  } ulf_frame_type;

endpackage

// file: dv/ulf_line_format_bench.sv
// Self-checking bench for the line format block.
`timescale 1ns/1ps
module ulf_line_format_bench;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, sb = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, tx_char = 8'h35, rdata, rx_char;
  logic line, tx_par, rx_par, rx_vld, perr, q_en, flow, reinit;
  ulf_pkg::ulf_frame_type frame;
  int errors = 0, tests_run = 0, cycles = 0;
  ulf_line_format ulf_line_format_i (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_tx_shift_bit(sb), .i_tx_char(tx_char),
    .o_serial_tx_line(line), .o_tx_parity_bit(tx_par), .i_rx_char(rx_char),
    .i_rx_parity_bit(rx_par), .i_rx_char_valid(rx_vld),
    .o_rx_parity_err(perr), .o_frame(frame), .o_rx_queue_enable(q_en),
    .o_rx_flow_ctrl_on(flow), .o_rx_queue_reinit(reinit));
  ulf_serial_peer ulf_serial_peer_i (.i_clk(clk), .o_char(rx_char),
    .o_parity_bit(rx_par), .o_valid(rx_vld));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    sb <= ~sb;
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic t_format;
    for (int i = 0; i < 16; i++) begin
      wr_reg(2'h0, 8'(i));
      rd_chk(2'h0, 8'(i));
      chk(frame, {4'h5 + 4'(i % 4), !i[2] ? 3'h2 :
        (i % 4 == 0) ? 3'h3 : 3'h4, i[3]});
    end
    wr_reg(2'h0, 8'hff);
    rd_chk(2'h0, 8'hff);
    wr_reg(2'h1, 8'h00);
    rd_chk(2'h0, 8'hff);
  endtask
  task automatic t_break;
    wr_reg(2'h0, 8'h40);
    rd_chk(2'h1, 8'h00);
    chk({7'h0, line}, 8'h00);
    wr_reg(2'h0, 8'h00);
    @(posedge clk);
    #1 chk({7'h0, line}, {7'h0, ~sb});
  endtask
  task automatic t_queue;
    wr_reg(2'h0, 8'h80);
    @(posedge clk);
    #1 chk({5'h0, q_en, flow, reinit}, 8'h07);
    @(posedge clk);
    #1 chk({5'h0, q_en, flow, reinit}, 8'h06);
    wr_reg(2'h0, 8'h00);
    @(posedge clk);
    #1 chk({5'h0, q_en, flow, reinit}, 8'h00);
  endtask
  task automatic t_parity;
    logic [7:0] f [7] = '{8'h03, 8'h1b, 8'h0b, 8'h0b, 8'h08, 8'h2b, 8'h3b};
    logic [6:0] p = 7'h17;
    logic [6:0] e = 7'h2a;
    logic [6:0] t = 7'h3e;
    for (int i = 0; i < 7; i++) begin
      wr_reg(2'h0, f[i]);
      tx_char <= (i == 4) ? 8'he3 : 8'h03 + 8'(i);
      ulf_serial_peer_i.send((i == 4) ? 8'he3 : 8'h03, p[i]);
      #1 chk({7'h0, perr}, {7'h0, e[i]});
      if (i > 0) begin
        chk({7'h0, tx_par}, {7'h0, t[i]});
      end
    end
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(2'h3, 8'h00);
    chk(frame, 8'h54);
    t_format();
    t_break();
    t_queue();
    t_parity();
    report_and_stop();
  end
endmodule

// file: dv/ulf_line_format_properties.sv
// Checker for the line format block, attached to its ports by bind.
`timescale 1ns/1ps

module ulf_line_format_properties (
  // Clock and reset
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_b,
  // Register port
  input  wire logic [ulf_pkg::ADDR_W-1:0]    i_reg_addr,
  input  wire logic [ulf_pkg::DATA_W-1:0]    i_reg_wdata,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  input  wire logic [ulf_pkg::DATA_W-1:0]    o_reg_rdata,
  // Transmit side
  input  wire logic                          i_tx_shift_bit,
  input  wire logic [7:0]                    i_tx_char,
  input  wire logic                          o_serial_tx_line,
  input  wire logic                          o_tx_parity_bit,
  // Frame setup and queue control
  input  wire ulf_pkg::ulf_frame_type        o_frame,
  input  wire logic                          o_rx_queue_enable,
  input  wire logic                          o_rx_flow_ctrl_on,
  input  wire logic                          o_rx_queue_reinit
);

  // Shadow of the format register, so outputs are tied to what was written.
  logic [7:0] fmt_r;
  logic [7:0] mask;
  logic       par_exp;
  logic       rst_seen_r;

  // Checking starts one edge after release, so no attempt begun on the last
  // reset edge compares reset values against the first decode.
  always_ff @(posedge i_core_clk) begin
    rst_seen_r <= i_rst_b;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      fmt_r <= 8'h00;
    end else if (i_reg_wr && i_reg_addr == 2'h0) begin
      fmt_r <= i_reg_wdata;
    end
  end

  assign mask    = 8'hff >> (2'h3 - fmt_r[1:0]);
  assign par_exp = fmt_r[5] ? !fmt_r[4] : ^(i_tx_char & mask) ^ !fmt_r[4];

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b || !rst_seen_r);

  sequence s_clear_set;
    !fmt_r[7] ##1 fmt_r[7];
  endsequence

  a_size_decode: assert property (
    1'b1 |=> o_frame.char_bits == 4'h5 + $past(fmt_r[1:0]))
    else $error("size bad");
  a_stop_decode: assert property (
    1'b1 |=> o_frame.stop_half_bits == (!$past(fmt_r[2]) ? 3'h2 :
      ($past(fmt_r[1:0]) == 2'h0) ? 3'h3 : 3'h4))
    else $error("stop length bad");
  a_parity_flag: assert property (
    1'b1 |=> o_frame.parity_on == $past(fmt_r[3]))
    else $error("parity flag bad");
  a_break_low: assert property (
    fmt_r[6] |=> !o_serial_tx_line)
    else $error("break not low");
  a_line_follows: assert property (
    !fmt_r[6] |=> o_serial_tx_line == $past(i_tx_shift_bit))
    else $error("line bad");
  a_reinit_pulse: assert property (
    s_clear_set |=> o_rx_queue_reinit)
    else $error("no reinit pulse");
  a_reinit_only: assert property (
    !(!$past(fmt_r[7]) && fmt_r[7]) |=> !o_rx_queue_reinit)
    else $error("stray reinit pulse");
  a_queue_copy: assert property (
    1'b1 |=> o_rx_queue_enable == $past(fmt_r[7]) &&
      o_rx_flow_ctrl_on == $past(fmt_r[7]))
    else $error("queue enable bad");
  a_read_back: assert property (
    i_reg_rd && i_reg_addr == 2'h0 |=> o_reg_rdata == $past(fmt_r))
    else $error("read back bad");
  a_tx_parity: assert property (
    fmt_r[3] |=> o_tx_parity_bit == $past(par_exp))
    else $error("tx parity bad");
endmodule

bind ulf_line_format ulf_line_format_properties ulf_line_format_properties_i (
  .i_core_clk        (i_core_clk),
  .i_rst_b           (i_rst_b),
  .i_reg_addr        (i_reg_addr),
  .i_reg_wdata       (i_reg_wdata),
  .i_reg_wr          (i_reg_wr),
  .i_reg_rd          (i_reg_rd),
  .o_reg_rdata       (o_reg_rdata),
  .i_tx_shift_bit    (i_tx_shift_bit),
  .i_tx_char         (i_tx_char),
  .o_serial_tx_line  (o_serial_tx_line),
  .o_tx_parity_bit   (o_tx_parity_bit),
  .o_frame           (o_frame),
  .o_rx_queue_enable (o_rx_queue_enable),
  .o_rx_flow_ctrl_on (o_rx_flow_ctrl_on),
  .o_rx_queue_reinit (o_rx_queue_reinit)
);

// file: dv/ulf_serial_peer.sv
// Remote serial peer handing received characters to the block.
`timescale 1ns/1ps
module ulf_serial_peer (
  input  wire logic       i_clk,
  output logic      [7:0] o_char = 8'h00,
  output logic            o_parity_bit = 1'b0,
  output logic            o_valid = 1'b0
);
  // After the strobe the lines show inverted junk, not the last character.
  task automatic send(input logic [7:0] c, input logic p);
    @(posedge i_clk);
    o_char <= c;
    o_parity_bit <= p;
    o_valid <= 1'b1;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_char <= ~c;
    o_parity_bit <= ~p;
  endtask
endmodule
